// ==== corr_err_params.svh ====
`ifndef CORR_ERR_PARAMS_SVH
`define CORR_ERR_PARAMS_SVH

`define REG_THRESH_BASE 8'h00
`define REG_COUNT_BASE 8'h0C
`define REG_STATUS 8'h18
`define REG_STRIDE 8'h04

`define STAT_IRQ_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_IC_PEND_BIT 2
`define STAT_IF_PEND_BIT 3

`define THRESH_RESET 32'h0000_0000

`define SRC_IC 0
`define SRC_INSTR_TIGHTLY_COUPLED_MEM 1
`define SRC_DATA_TIGHTLY_COUPLED_MEM 2
`define NUM_SRC 3

`endif

// ==== corr_err_pkg.sv ====
package corr_err_pkg;
	typedef enum {
		IDLE,
		IC_INVAL,
		IC_FLUSH,
		IC_REFILL,
		IF_FLUSH,
		IF_WB,
		IF_REFETCH
	} recov_state_t;
	typedef logic [1:0] inc_amt_t;
endpackage

// ==== correctable_mem_error_handler.sv ====
// Design decisions made here: the APB register port and the register offsets.
`include "corr_err_params.svh"

module correctable_mem_error_handler #(
	parameter int CNT_W = 16,
	parameter int IDX_W = 6,
	parameter int AW = 16,
	parameter int DW = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic icSglErr,
	input wire logic icDblErr,
	input wire logic [IDX_W-1:0] icFetchSet,
	input wire logic iccmFetchErr,
	input wire logic [AW-1:0] iccmFetchAddr,
	input wire logic [DW-1:0] iccmFetchData,
	input wire logic dccmLsErr,
	input wire logic dccmLsNonSpec,
	input wire logic [AW-1:0] dccmLsAddr,
	input wire logic [DW-1:0] dccmLsData,
	input wire logic dmaValid,
	input wire logic dmaWrite,
	input wire logic dmaIccm,
	input wire logic dmaErr,
	input wire logic [AW-1:0] dmaAddr,
	input wire logic [DW-1:0] dmaData,
	output logic icInvalSet,
	output logic [IDX_W-1:0] icInvalIdx,
	output logic refetchPcFlush,
	output logic icRefill,
	output logic iccmRefetch,
	output logic iccmWbEn,
	output logic [AW-1:0] iccmWbAddr,
	output logic [DW-1:0] iccmWbData,
	output logic dccmWbEn,
	output logic [AW-1:0] dccmWbAddr,
	output logic [DW-1:0] dccmWbData,
	output logic corrIrq
);
	if (CNT_W < 2 || CNT_W > 32 || IDX_W < 1 || AW < 1 || DW < 1) begin : gParamCheck
		$error("unsupported parameter values");
	end

	corr_err_pkg::recov_state_t state_q;
	corr_err_pkg::recov_state_t state_d;

	// error events of the current cycle
	logic icErrEv;
	logic iccmEv;
	logic lsEv;
	logic dmaRdErr;
	logic dmaIccmEv;
	logic dmaDccmEv;
	assign icErrEv = icSglErr | icDblErr;
	assign iccmEv = iccmFetchErr;
	assign lsEv = dccmLsErr & dccmLsNonSpec;
	assign dmaRdErr = dmaValid & ~dmaWrite & dmaErr;
	assign dmaIccmEv = dmaRdErr & dmaIccm;
	assign dmaDccmEv = dmaRdErr & ~dmaIccm;

	// recovery requests waiting for the sequencer
	logic icPend_q;
	logic ifPend_q;
	logic [IDX_W-1:0] icPendSet_q;
	logic [AW-1:0] ifPendAddr_q;
	logic [DW-1:0] ifPendData_q;
	logic [IDX_W-1:0] icWorkSet_q;
	logic [AW-1:0] ifWorkAddr_q;
	logic [DW-1:0] ifWorkData_q;
	logic icTake;
	logic ifTake;
	assign icTake = (state_q == corr_err_pkg::IDLE) & icPend_q;
	assign ifTake = (state_q == corr_err_pkg::IDLE) & ~icPend_q & ifPend_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			icPend_q <= 1'b0;
			ifPend_q <= 1'b0;
			icPendSet_q <= '0;
			ifPendAddr_q <= '0;
			ifPendData_q <= '0;
		end else begin
			// a new error in the take cycle keeps the request alive
			icPend_q <= icErrEv | (icPend_q & ~icTake);
			ifPend_q <= iccmEv | (ifPend_q & ~ifTake);
			if (icErrEv) begin
				icPendSet_q <= icFetchSet;
			end
			if (iccmEv) begin
				ifPendAddr_q <= iccmFetchAddr;
				ifPendData_q <= iccmFetchData;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			icWorkSet_q <= '0;
			ifWorkAddr_q <= '0;
			ifWorkData_q <= '0;
		end else begin
			if (icTake) begin
				icWorkSet_q <= icPendSet_q;
			end
			if (ifTake) begin
				ifWorkAddr_q <= ifPendAddr_q;
				ifWorkData_q <= ifPendData_q;
			end
		end
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			corr_err_pkg::IDLE: begin
				if (icPend_q) begin
					state_d = corr_err_pkg::IC_INVAL;
				end else if (ifPend_q) begin
					state_d = corr_err_pkg::IF_FLUSH;
				end
			end
			corr_err_pkg::IC_INVAL: state_d = corr_err_pkg::IC_FLUSH;
			corr_err_pkg::IC_FLUSH: state_d = corr_err_pkg::IC_REFILL;
			corr_err_pkg::IC_REFILL: state_d = corr_err_pkg::IDLE;
			corr_err_pkg::IF_FLUSH: begin
				// the write port is busy with a DMA write-back this cycle
				if (!dmaIccmEv) begin
					state_d = corr_err_pkg::IF_WB;
				end
			end
			corr_err_pkg::IF_WB: state_d = corr_err_pkg::IF_REFETCH;
			corr_err_pkg::IF_REFETCH: state_d = corr_err_pkg::IDLE;
		endcase
	end

	logic enterIfFlush;
	logic fsmIccmWb;
	assign enterIfFlush = (state_d == corr_err_pkg::IF_FLUSH) && (state_q != corr_err_pkg::IF_FLUSH);
	assign fsmIccmWb = (state_d == corr_err_pkg::IF_WB);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= corr_err_pkg::IDLE;
			icInvalSet <= 1'b0;
			icInvalIdx <= '0;
			refetchPcFlush <= 1'b0;
			icRefill <= 1'b0;
			iccmRefetch <= 1'b0;
		end else begin
			state_q <= state_d;
			icInvalSet <= (state_d == corr_err_pkg::IC_INVAL);
			icInvalIdx <= icTake ? icPendSet_q : icWorkSet_q;
			refetchPcFlush <= (state_d == corr_err_pkg::IC_FLUSH) | enterIfFlush;
			icRefill <= (state_d == corr_err_pkg::IC_REFILL);
			iccmRefetch <= (state_d == corr_err_pkg::IF_REFETCH);
		end
	end

	// instruction memory write port: DMA read fix-ups go first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			iccmWbEn <= 1'b0;
			iccmWbAddr <= '0;
			iccmWbData <= '0;
		end else begin
			iccmWbEn <= dmaIccmEv | fsmIccmWb;
			if (dmaIccmEv) begin
				iccmWbAddr <= dmaAddr;
				iccmWbData <= dmaData;
			end else if (fsmIccmWb) begin
				iccmWbAddr <= ifWorkAddr_q;
				iccmWbData <= ifWorkData_q;
			end
		end
	end

	// data memory write port: load/store fix-ups go first, a DMA one waits
	logic dccmHold_q;
	logic [AW-1:0] dccmHoldAddr_q;
	logic [DW-1:0] dccmHoldData_q;
	logic holdLoad;
	assign holdLoad = dmaDccmEv & (lsEv | dccmHold_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dccmHold_q <= 1'b0;
			dccmHoldAddr_q <= '0;
			dccmHoldData_q <= '0;
		end else begin
			dccmHold_q <= holdLoad | (dccmHold_q & lsEv);
			if (holdLoad) begin
				dccmHoldAddr_q <= dmaAddr;
				dccmHoldData_q <= dmaData;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dccmWbEn <= 1'b0;
			dccmWbAddr <= '0;
			dccmWbData <= '0;
		end else begin
			dccmWbEn <= lsEv | dccmHold_q | dmaDccmEv;
			if (lsEv) begin
				dccmWbAddr <= dccmLsAddr;
				dccmWbData <= dccmLsData;
			end else if (dccmHold_q) begin
				dccmWbAddr <= dccmHoldAddr_q;
				dccmWbData <= dccmHoldData_q;
			end else if (dmaDccmEv) begin
				dccmWbAddr <= dmaAddr;
				dccmWbData <= dmaData;
			end
		end
	end

	// APB slave, one wait-free access phase
	logic setup;
	logic wrEn;
	logic mapped;
	logic [31:0] rdData;
	assign setup = psel & ~penable;
	assign wrEn = psel & penable & pready & pwrite & ~pslverr;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `REG_STATUS);

	corr_err_pkg::inc_amt_t incAmt [`NUM_SRC];
	logic [CNT_W-1:0] thresh_q [`NUM_SRC];
	logic [CNT_W-1:0] cntVal [`NUM_SRC];
	logic [`NUM_SRC-1:0] hit;
	logic [`NUM_SRC-1:0] cntClr;

	assign incAmt[`SRC_IC] = {1'b0, icErrEv};
	assign incAmt[`SRC_INSTR_TIGHTLY_COUPLED_MEM] = {1'b0, iccmEv} + {1'b0, dmaIccmEv};
	assign incAmt[`SRC_DATA_TIGHTLY_COUPLED_MEM] = {1'b0, lsEv} + {1'b0, dmaDccmEv};

	for (genvar g = 0; g < `NUM_SRC; g++) begin : gSrc
		localparam logic [7:0] THRESH_ADDR = `REG_THRESH_BASE + 8'(g * 4);
		localparam logic [7:0] COUNT_ADDR = `REG_COUNT_BASE + 8'(g * 4);
		err_cnt_if #(.CNT_W(CNT_W)) cif ();
		err_counter #(.CNT_W(CNT_W)) uCnt (
			.clk(clk),
			.rst(rst),
			.cif(cif)
		);
		assign cif.incAmt = incAmt[g];
		assign cif.clr = wrEn && (paddr == COUNT_ADDR);
		assign cif.thresh = thresh_q[g];
		assign cntVal[g] = cif.count;
		assign hit[g] = cif.hit;
		assign cntClr[g] = cif.clr;
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				thresh_q[g] <= CNT_W'(`THRESH_RESET);
			end else if (wrEn && (paddr == THRESH_ADDR)) begin
				thresh_q[g] <= pwdata[CNT_W-1:0];
			end
		end
	end

	always_comb begin
		rdData = 32'h0000_0000;
		for (int i = 0; i < `NUM_SRC; i++) begin
			if (paddr == `REG_THRESH_BASE + 8'(i * 4)) begin
				rdData[CNT_W-1:0] = thresh_q[i];
			end
			if (paddr == `REG_COUNT_BASE + 8'(i * 4)) begin
				rdData[CNT_W-1:0] = cntVal[i];
			end
		end
		if (paddr == `REG_STATUS) begin
			rdData[`STAT_IRQ_BIT] = corrIrq;
			rdData[`STAT_BUSY_BIT] = (state_q != corr_err_pkg::IDLE);
			rdData[`STAT_IC_PEND_BIT] = icPend_q;
			rdData[`STAT_IF_PEND_BIT] = ifPend_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			corrIrq <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup & ~pwrite & mapped) ? rdData : 32'h0000_0000;
			corrIrq <= |hit;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_ic_seq_order: assert property (icInvalSet |=> refetchPcFlush ##1 icRefill) else $error("I-cache recovery out of order");
	chk_ic_set_idx: assert property (icTake |=> icInvalSet && icInvalIdx == $past(icPendSet_q)) else $error("wrong set invalidated");
	chk_instr_tightly_coupled_mem_flush_first: assert property (ifTake |=> refetchPcFlush && !icInvalSet) else $error("no flush for fetch error");
	chk_instr_tightly_coupled_mem_wb_refetch: assert property (state_q == corr_err_pkg::IF_WB |-> iccmWbEn && iccmWbAddr == ifWorkAddr_q ##1 iccmRefetch) else $error("fetch fix-up write missing");
	chk_data_tightly_coupled_mem_inline_wb: assert property (lsEv |=> dccmWbEn && dccmWbAddr == $past(dccmLsAddr) && dccmWbData == $past(dccmLsData)) else $error("load/store write-back wrong");
	chk_spec_ignored: assert property (dccmLsErr && !dccmLsNonSpec && !dmaDccmEv && !dccmHold_q |=> !dccmWbEn) else $error("speculative access written back");
	chk_dma_instr_tightly_coupled_mem_wb: assert property (dmaIccmEv |=> iccmWbEn && iccmWbData == $past(dmaData)) else $error("DMA fix-up write missing");
	chk_dma_data_tightly_coupled_mem_wb: assert property (dmaDccmEv && !lsEv && !dccmHold_q |=> dccmWbEn && dccmWbAddr == $past(dmaAddr)) else $error("DMA data fix-up missing");
	chk_dma_wr_nocnt: assert property (dmaValid && dmaWrite && !iccmFetchErr && cntClr == '0 |=> $stable(cntVal[`SRC_INSTR_TIGHTLY_COUPLED_MEM])) else $error("DMA write counted");
	chk_irq_follows: assert property (hit != '0 |=> corrIrq) else $error("threshold without interrupt");
	chk_ic_counted: assert property (icErrEv && !cntClr[`SRC_IC] && cntVal[`SRC_IC] == '0 |=> cntVal[`SRC_IC] == 1) else $error("I-cache error not counted");

	cov_ic_recovery: cover property (icInvalSet ##1 refetchPcFlush ##1 icRefill);
	cov_instr_tightly_coupled_mem_recovery: cover property (ifTake ##[1:4] iccmWbEn ##1 iccmRefetch);
	cov_data_tightly_coupled_mem_dma_clash: cover property (lsEv && dmaDccmEv);
	cov_irq: cover property ($rose(corrIrq));
endmodule // correctable_mem_error_handler

// ==== correctable_mem_error_handler_bench.sv ====
module correctable_mem_error_handler_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, er, corrIrq;
	logic icSglErr, icDblErr, iccmFetchErr, dccmLsErr, dccmLsNonSpec;
	logic dmaValid, dmaWrite, dmaIccm, dmaErr, icInvalSet, icRefill, refetchPcFlush;
	logic iccmRefetch, iccmWbEn, dccmWbEn;
	logic [7:0] paddr;
	logic [5:0] icFetchSet, icInvalIdx;
	logic [15:0] iccmFetchAddr, dccmLsAddr, dmaAddr, iccmWbAddr, dccmWbAddr, a;
	logic [31:0] pwdata, prdata, rd, d, iccmFetchData, dccmLsData, dmaData, iccmWbData, dccmWbData;
	int error_cnt, n_compared, i, n, k, v;
	int cnt[3], thr[3];

	localparam int CW = 4;

	correctable_mem_error_handler #(.CNT_W(CW)) u_correctable_mem_error_handler (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.icSglErr(icSglErr), .icDblErr(icDblErr), .icFetchSet(icFetchSet),
		.iccmFetchErr(iccmFetchErr), .iccmFetchAddr(iccmFetchAddr), .iccmFetchData(iccmFetchData),
		.dccmLsErr(dccmLsErr), .dccmLsNonSpec(dccmLsNonSpec), .dccmLsAddr(dccmLsAddr),
		.dccmLsData(dccmLsData), .dmaValid(dmaValid), .dmaWrite(dmaWrite), .dmaIccm(dmaIccm),
		.dmaErr(dmaErr), .dmaAddr(dmaAddr), .dmaData(dmaData), .icInvalSet(icInvalSet),
		.icInvalIdx(icInvalIdx), .refetchPcFlush(refetchPcFlush), .icRefill(icRefill),
		.iccmRefetch(iccmRefetch), .iccmWbEn(iccmWbEn), .iccmWbAddr(iccmWbAddr),
		.iccmWbData(iccmWbData), .dccmWbEn(dccmWbEn), .dccmWbAddr(dccmWbAddr),
		.dccmWbData(dccmWbData), .corrIrq(corrIrq)
	);
	mem_side_model u_mem_side_model (
		.clk(clk), .icInvalSet(icInvalSet), .icInvalIdx(icInvalIdx),
		.refetchPcFlush(refetchPcFlush), .icRefill(icRefill), .iccmRefetch(iccmRefetch),
		.iccmWbEn(iccmWbEn), .iccmWbAddr(iccmWbAddr), .iccmWbData(iccmWbData),
		.dccmWbEn(dccmWbEn), .dccmWbAddr(dccmWbAddr), .dccmWbData(dccmWbData)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task finish_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int j;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		for (j = 0; j < 16; j++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (j == 16) begin
			check(32'h0, 32'h1, "bus timeout");
			finish_test();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task rdchk(input logic [7:0] ad, input logic [31:0] exp, input logic expErr);
		apb(1'b0, ad, 32'h0);
		check(rd, exp, "read data");
		check({31'h0, er}, {31'h0, expErr}, "slave error");
	endtask

	function logic [31:0] stat();
		for (int s = 0; s < 3; s++)
			if (thr[s] != 0 && cnt[s] >= thr[s]) return 32'h1;
		return 32'h0;
	endfunction

	function void bump(input int s);
		if (cnt[s] < (1 << CW) - 1) cnt[s]++;
	endfunction

	function int expLog(input int kind);
		case (kind)
			0, 1: return 123;
			2: return 245;
			3, 6: return 6;
			5: return 4;
			9: return 66;
			default: return 0;
		endcase
	endfunction

	task ev();
		@(posedge clk);
		icSglErr <= (k == 0);
		icDblErr <= (k == 1);
		icFetchSet <= a[5:0];
		iccmFetchErr <= (k == 2);
		iccmFetchAddr <= a;
		iccmFetchData <= d;
		dccmLsErr <= (k == 3 || k == 4 || k == 9);
		dccmLsNonSpec <= (k != 4);
		dccmLsAddr <= a;
		dccmLsData <= d;
		dmaValid <= (k >= 5);
		dmaWrite <= (k == 7 || k == 8);
		dmaIccm <= (k == 5 || k == 7 || (k == 10 && a[3]));
		dmaErr <= (k >= 5 && k != 10);
		dmaAddr <= a ^ 16'h0004;
		dmaData <= ~d;
		@(posedge clk);
		icSglErr <= 1'b0;
		icDblErr <= 1'b0;
		iccmFetchErr <= 1'b0;
		dccmLsErr <= 1'b0;
		dmaValid <= 1'b0;
		dmaErr <= 1'b0;
		if (k < 2) bump(0);
		if (k == 2 || k == 5) bump(1);
		if (k == 3 || k == 6 || k == 9) bump(2);
		if (k == 9) bump(2);
	endtask

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, icSglErr, icDblErr, iccmFetchErr, dccmLsErr} = 7'h00;
		{dccmLsNonSpec, dmaValid, dmaWrite, dmaIccm, dmaErr} = 5'h00;
		{paddr, pwdata, icFetchSet} = '0;
		{iccmFetchAddr, iccmFetchData, dccmLsAddr, dccmLsData, dmaAddr, dmaData} = '0;
		void'($urandom(50));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 7; i++) rdchk(8'(4 * i), 32'h0, 1'b0);
		rdchk(8'h1C, 32'h0, 1'b1);
		rdchk(8'h02, 32'h0, 1'b1);
		apb(1'b1, 8'h18, 32'hFFFFFFFF);
		rdchk(8'h18, 32'h0, 1'b0);
		$display("test reset done");
		for (i = 0; i < 3; i++) begin
			thr[i] = 1 + $urandom % 4;
			apb(1'b1, 8'(4 * i), 32'(thr[i]));
			rdchk(8'(4 * i), 32'(thr[i]), 1'b0);
		end
		for (n = 0; n < 60; n++) begin
			k = (n < 11) ? n : $urandom % 11;
			a = 16'($urandom) & 16'hFFF8;
			d = $urandom;
			u_mem_side_model.evLog.delete();
			u_mem_side_model.iccmMem.delete();
			u_mem_side_model.dccmMem.delete();
			ev();
			repeat (8) @(posedge clk);
			v = 0;
			foreach (u_mem_side_model.evLog[j]) v = v * 10 + u_mem_side_model.evLog[j];
			check(32'(v), 32'(expLog(k)), "action order");
			if (k < 2) check(32'(u_mem_side_model.lastIdx), 32'(a[5:0]), "set");
			if (k == 2) check(u_mem_side_model.iccmMem[int'(a)], d, "instr wb");
			if (k == 5) check(u_mem_side_model.iccmMem[int'(a ^ 16'h4)], ~d, "dma wb");
			if (k == 3 || k == 9) check(u_mem_side_model.dccmMem[int'(a)], d, "ls wb");
			if (k == 6 || k == 9) check(u_mem_side_model.dccmMem[int'(a ^ 16'h4)], ~d, "dma");
			for (i = 0; i < 3; i++) rdchk(8'(12 + 4 * i), 32'(cnt[i]), 1'b0);
			rdchk(8'h18, stat(), 1'b0);
			check({31'h0, corrIrq}, stat(), "irq pin");
			if (n == 30) begin
				for (i = 0; i < 3; i++) begin
					apb(1'b1, 8'(12 + 4 * i), 32'h0);
					cnt[i] = 0;
				end
				rdchk(8'h18, stat(), 1'b0);
				$display("test clear done");
			end
		end
		$display("test events done");
		finish_test();
	end
endmodule // correctable_mem_error_handler_bench

// ==== err_cnt_if.sv ====
interface err_cnt_if #(parameter int CNT_W = 16);
	corr_err_pkg::inc_amt_t incAmt;
	logic clr;
	logic [CNT_W-1:0] thresh;
	logic [CNT_W-1:0] count;
	logic hit;
	modport cnt (input incAmt, input clr, input thresh, output count, output hit);
	modport ctl (output incAmt, output clr, output thresh, input count, input hit);
endinterface

// ==== err_counter.sv ====
module err_counter #(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	err_cnt_if.cnt cif
);
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic hit_q;
	logic hit_d;
	logic [CNT_W:0] sum;
	logic [CNT_W-1:0] satSum;

	// clear restarts from zero but an increment in the same cycle still counts
	assign sum = {1'b0, count_q} + {{(CNT_W-1){1'b0}}, cif.incAmt};
	assign satSum = sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0];
	assign count_d = cif.clr ? {{(CNT_W-2){1'b0}}, cif.incAmt} : satSum;
	assign hit_d = (cif.thresh != '0) && (count_d >= cif.thresh);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
			hit_q <= 1'b0;
		end else begin
			count_q <= count_d;
			hit_q <= hit_d;
		end
	end

	assign cif.count = count_q;
	assign cif.hit = hit_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_count_saturate: assert property (count_q == {CNT_W{1'b1}} && !cif.clr |=> count_q == {CNT_W{1'b1}}) else $error("counter wrapped");
	chk_count_step: assert property (!cif.clr && sum[CNT_W] == 1'b0 |=> count_q == $past(count_q) + $past({{(CNT_W-2){1'b0}}, cif.incAmt})) else $error("counter step wrong");
	chk_hit_thresh: assert property (##1 $stable(cif.thresh) |-> hit_q == ((cif.thresh != '0) && (count_q >= cif.thresh))) else $error("hit disagrees with threshold");
	cov_saturated: cover property (count_q == {CNT_W{1'b1}});
endmodule // err_counter

// ==== mem_side_model.sv ====
module mem_side_model #(
	parameter int AW = 16,
	parameter int DW = 32
) (
	input wire logic clk,
	input wire logic icInvalSet,
	input wire logic [5:0] icInvalIdx,
	input wire logic refetchPcFlush,
	input wire logic icRefill,
	input wire logic iccmRefetch,
	input wire logic iccmWbEn,
	input wire logic [AW-1:0] iccmWbAddr,
	input wire logic [DW-1:0] iccmWbData,
	input wire logic dccmWbEn,
	input wire logic [AW-1:0] dccmWbAddr,
	input wire logic [DW-1:0] dccmWbData
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DW-1:0] iccmMem [int];
	logic [DW-1:0] dccmMem [int];
	logic [5:0] lastIdx;
	int evLog[$];
	// bus memories fix, count and interrupt on their own, nothing reaches here
	always @(posedge clk) begin
		if (icInvalSet) begin
			evLog.push_back(1);
			lastIdx <= icInvalIdx;
		end
		if (refetchPcFlush) evLog.push_back(2);
		if (icRefill) evLog.push_back(3);
		if (iccmWbEn) begin
			evLog.push_back(4);
			iccmMem[int'(iccmWbAddr)] = iccmWbData;
		end
		if (iccmRefetch) evLog.push_back(5);
		if (dccmWbEn) begin
			evLog.push_back(6);
			dccmMem[int'(dccmWbAddr)] = dccmWbData;
		end
	end
endmodule // mem_side_model
